// ===== logic/dtd_digit_out.v
// dtd_digit_out: tone and pause timing, code latch and output drive
// assumes: tone flag, row and column come from the analog detector,
// asynchronous to clk_i; the reader uses the three-state code bus
// What this block does
// - format select high gives hexadecimal code
// - format select low gives 2-of-8 code
// - hex maps digits to their table values
// - inhibit high blocks the fourth column
// - code driven only while output enable high
// - code valid on detect, cleared after pause
// - valid high until pause or valid clear
// - early detect follows tone and pause onset
// - accept tones of 40 ms, reject 20
// - pauses of 40 ms valid, gaps ignored
// - valid rises 25 to 46 ms after onset
// - valid falls 35 to 50 ms after end
// - code set 7 us early, held ~4.6 ms
// - valid clear drops valid within 250 ns
// - early detect 7-22 ms on, 2-18 off
// - master drives shared time base to slaves
// - reduced variant hex only, no valid clear
// - 2-of-8 values for digits and star
`timescale 1ns/1ns
`include "dtd_consts.vh"
module dtd_digit_out #(
  parameter MS_CYC   = `DTD_MS_CYC,
  parameter HOLD_CYC = `DTD_HOLD_CYC,
  parameter REDUCED  = 0
) (
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire       tone_present_i,
  input  wire [1:0] tone_row_i,
  input  wire [1:0] tone_col_i,
  input  wire       output_format_select_i,
  input  wire       fourth_column_inhibit_i,
  input  wire       output_enable_i,
  input  wire       valid_clear_i,
  input  wire       oscillator_enable_i,
  input  wire       shared_time_base_i,
  output wire       shared_time_base_o,
  output wire       shared_time_base_oe_o,
  output wire       code_bit0_o,
  output wire       code_bit1_o,
  output wire       code_bit2_o,
  output wire       code_bit3_o,
  output wire       code_oe_o,
  output wire       digit_valid_o,
  output wire       early_detect_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_SETUP = 2'h1;
  localparam ST_VALID = 2'h2;
  localparam ST_HOLD  = 2'h3;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [8:0]  sync1_ff;
  reg  [8:0]  sync2_ff;
  reg         vc_d_ff;
  reg  [3:0]  last_digit_ff;
  reg  [5:0]  tone_ms_ff;
  reg  [5:0]  gap_ms_ff;
  reg  [1:0]  state_ff;
  reg  [16:0] cnt_ff;
  reg         dv_ff;
  reg         ed_ff;
  reg  [3:0]  code_ff;
  reg  [5:0]  nxt_tone_ms;
  reg  [5:0]  nxt_gap_ms;
  reg  [1:0]  nxt_state;
  reg  [16:0] nxt_cnt;
  reg         nxt_dv;
  reg         nxt_ed;
  reg  [3:0]  nxt_code;
  wire        ms_tick;
  wire        tone_s;
  wire [3:0]  digit_s;
  wire        fmt_s;
  wire        inhibit_s;
  wire        oe_s;
  wire        vc_s;
  wire        col_ok;
  wire        tone_on;
  wire        fmt_hex;
  wire        vc_rise;
  wire        tone_ok;
  wire        pause_ok;
  wire [3:0]  enc_code;
  wire        digit_chg;
  wire        setup_done;
  wire        hold_done;
  wire [3:0]  code_pin;
  genvar      gi;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  dtd_time_base #(
    .MS_CYC (MS_CYC)
  ) u_time_base (
    .clk_i                 (clk_i),
    .nrst_i                (nrst_i),
    .oscillator_enable_i   (oscillator_enable_i),
    .shared_time_base_i    (shared_time_base_i),
    .shared_time_base_o    (shared_time_base_o),
    .shared_time_base_oe_o (shared_time_base_oe_o),
    .ms_tick_o             (ms_tick)
  );

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    sync1_ff <= {valid_clear_i, output_enable_i, fourth_column_inhibit_i,
                 output_format_select_i, tone_col_i, tone_row_i,
                 tone_present_i};
    sync2_ff <= sync1_ff;
  end

  assign tone_s    = sync2_ff[0];
  assign digit_s   = {sync2_ff[2:1], sync2_ff[4:3]};
  assign fmt_s     = sync2_ff[5];
  assign inhibit_s = sync2_ff[6];
  assign oe_s      = sync2_ff[7];
  assign vc_s      = sync2_ff[8];

  // ----------------------------------------------------------------
  // tone qualification
  // ----------------------------------------------------------------
  // fourth column blocked while inhibited
  assign col_ok  = ~(inhibit_s && digit_s[1:0] == `DTD_COL_INHIBIT);
  // row and column pick one of sixteen digits
  assign tone_on = tone_s & col_ok;
  assign fmt_hex = fmt_s | (REDUCED != 0);
  // valid clear edge seen two clocks after the pin
  assign vc_rise = vc_s & ~vc_d_ff & (REDUCED == 0);
  // steady digit for the minimum tone time
  assign tone_ok  = (tone_ms_ff >= `DTD_TONE_MIN_MS);
  // gap long enough to count as a pause
  assign pause_ok = (gap_ms_ff >= `DTD_PAUSE_MIN_MS);

  dtd_code_encoder u_encoder (
    .digit_i (digit_s),
    .hex_i   (fmt_hex),
    .code_o  (enc_code)
  );

  // ----------------------------------------------------------------
  // sequencer terms
  // ----------------------------------------------------------------
  // a new matrix position restarts timing
  assign digit_chg  = (digit_s != last_digit_ff);
  // setup time before valid is over
  assign setup_done = (cnt_ff == `DTD_SETUP_CYC - 1);
  // hold time after valid is over
  assign hold_done  = (cnt_ff == HOLD_CYC - 1);

  // ----------------------------------------------------------------
  // duration counters
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_tone_ms = tone_ms_ff;
    nxt_gap_ms  = gap_ms_ff;
    // a changed digit restarts the tone time
    if (!tone_on || digit_chg)
      nxt_tone_ms = 6'h0;
    else if (ms_tick && tone_ms_ff != `DTD_MS_SAT)
      nxt_tone_ms = tone_ms_ff + 6'h1;
    // short gaps restart with the next tone
    if (tone_on)
      nxt_gap_ms = 6'h0;
    else if (ms_tick && gap_ms_ff != `DTD_MS_SAT)
      nxt_gap_ms = gap_ms_ff + 6'h1;
  end

  // ----------------------------------------------------------------
  // early detect
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_ed = ed_ff;
    // rises once a tone pair is being seen
    // rise after the early on time
    if (tone_ms_ff >= `DTD_ED_ON_MS)
      nxt_ed = 1'b1;
    // fall after the early off time
    else if (gap_ms_ff >= `DTD_ED_OFF_MS)
      nxt_ed = 1'b0;
  end

  // ----------------------------------------------------------------
  // digit sequencer
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_dv    = dv_ff;
    nxt_code  = code_ff;
    if (vc_rise)
      nxt_dv = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_cnt = 17'h0;
        if (tone_ok)
        begin
          nxt_code  = enc_code;
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // code stands the setup time before valid
        if (setup_done)
        begin
          nxt_cnt   = 17'h0;
          // valid rises after tone time plus setup
          // raise wins over a clear in the same cycle
          nxt_dv    = 1'b1;
          nxt_state = ST_VALID;
        end
        else
          nxt_cnt = cnt_ff + 17'h1;
      end
      ST_VALID:
      begin
        // valid falls after the pause time
        if (pause_ok)
        begin
          nxt_dv    = 1'b0;
          nxt_cnt   = 17'h0;
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (hold_done)
        begin
          // code cleared after the valid pause
          nxt_code  = `DTD_CODE_RST;
          nxt_cnt   = 17'h0;
          nxt_state = ST_IDLE;
        end
        else
          nxt_cnt = cnt_ff + 17'h1;
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_cnt   = 17'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // input history registers
  // ----------------------------------------------------------------
  // previous clear level for edge detect
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      vc_d_ff       <= 1'b0;
      last_digit_ff <= 4'h0;
    end
    else
    begin
      vc_d_ff       <= vc_s;
      last_digit_ff <= digit_s;
    end
  end

  // ----------------------------------------------------------------
  // duration registers
  // ----------------------------------------------------------------
  // durations start from zero at reset
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      tone_ms_ff    <= 6'h0;
      gap_ms_ff     <= 6'h0;
      ed_ff         <= 1'b0;
    end
    else
    begin
      tone_ms_ff    <= nxt_tone_ms;
      gap_ms_ff     <= nxt_gap_ms;
      ed_ff         <= nxt_ed;
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // outputs clear and valid low at reset
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state_ff      <= ST_IDLE;
      cnt_ff        <= 17'h0;
      dv_ff         <= 1'b0;
      code_ff       <= `DTD_CODE_RST;
    end
    else
    begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      dv_ff         <= nxt_dv;
      code_ff       <= nxt_code;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // code bus driven only while enabled
  assign code_oe_o      = oe_s;
  // each code pin follows its latched bit
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_code_pin
      assign code_pin[gi] = code_ff[gi];
    end
  endgenerate
  assign code_bit0_o    = code_pin[0];
  assign code_bit1_o    = code_pin[1];
  assign code_bit2_o    = code_pin[2];
  assign code_bit3_o    = code_pin[3];
  // valid marks when the code may be read
  assign digit_valid_o  = dv_ff;
  assign early_detect_o = ed_ff;

endmodule // dtd_digit_out

// ===== logic/dtd_consts.vh
// dtd_consts.vh: timing counts and code values for the digit output logic
// assumes: included by bare name; clk_i runs at DTD_CLK_MHZ
`ifndef DTD_CONSTS_VH
`define DTD_CONSTS_VH

// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define DTD_CLK_MHZ       25
`define DTD_MS_US         1000
`define DTD_MS_CYC        (`DTD_MS_US * `DTD_CLK_MHZ)
// shared time base toggles every half period, about 446 khz
`define DTD_TB_HALF_CYC   28
// shared time base rising edges that make up one millisecond
`define DTD_TB_EDGES_MS   447

// ----------------------------------------------------------------
// durations in milliseconds
// ----------------------------------------------------------------
`define DTD_TONE_MIN_MS   6'h1e
`define DTD_PAUSE_MIN_MS  6'h26
`define DTD_ED_ON_MS      6'h0a
`define DTD_ED_OFF_MS     6'h08
`define DTD_MS_SAT        6'h3f

// ----------------------------------------------------------------
// setup and hold of the code outputs
// ----------------------------------------------------------------
`define DTD_SETUP_NS      7000
`define DTD_SETUP_CYC     ((`DTD_SETUP_NS * `DTD_CLK_MHZ + 999) / 1000)
`define DTD_HOLD_US       4600
`define DTD_HOLD_CYC      (`DTD_HOLD_US * `DTD_CLK_MHZ)

// ----------------------------------------------------------------
// reset values and matrix position of the inhibited column
// ----------------------------------------------------------------
`define DTD_CODE_RST      4'h0
`define DTD_COL_INHIBIT   2'h3

`endif

// ===== logic/dtd_code_encoder.v
// dtd_code_encoder: maps a matrix position to the output code
// assumes: digit_i is {row, column}, both two bits, from the tone detector
`timescale 1ns/1ns
module dtd_code_encoder (
  input  wire [3:0] digit_i,
  input  wire       hex_i,
  output reg  [3:0] code_o
);

  reg [3:0] hex_code;

  // ----------------------------------------------------------------
  // hex table: rows 1 2 3 A / 4 5 6 B / 7 8 9 C / * 0 # D
  // ----------------------------------------------------------------
  // hex digit values
  always @*
  begin
    case (digit_i)
      4'h0: hex_code = 4'h1;
      4'h1: hex_code = 4'h2;
      4'h2: hex_code = 4'h3;
      4'h3: hex_code = 4'hd;
      4'h4: hex_code = 4'h4;
      4'h5: hex_code = 4'h5;
      4'h6: hex_code = 4'h6;
      4'h7: hex_code = 4'he;
      4'h8: hex_code = 4'h7;
      4'h9: hex_code = 4'h8;
      4'ha: hex_code = 4'h9;
      4'hb: hex_code = 4'hf;
      4'hc: hex_code = 4'hb;
      4'hd: hex_code = 4'ha;
      4'he: hex_code = 4'hc;
      default: hex_code = 4'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // format select
  // ----------------------------------------------------------------
  always @*
  begin
    if (hex_i)
      code_o = hex_code;
    // raw {row, column} position for every key
    else
      code_o = digit_i;
  end

endmodule // dtd_code_encoder

// ===== logic/dtd_time_base.v
// dtd_time_base: millisecond tick from own clock or a shared time base
// assumes: strap and shared time base pin are asynchronous to clk_i
`timescale 1ns/1ns
`include "dtd_consts.vh"
module dtd_time_base #(
  parameter MS_CYC = `DTD_MS_CYC
) (
  input  wire clk_i,
  input  wire nrst_i,
  input  wire oscillator_enable_i,
  input  wire shared_time_base_i,
  output wire shared_time_base_o,
  output wire shared_time_base_oe_o,
  output reg  ms_tick_o
);

  reg        strap_s1_ff;
  reg        strap_s2_ff;
  reg        strap_done_ff;
  reg        master_ff;
  reg        tb_s1_ff;
  reg        tb_s2_ff;
  reg        tb_d_ff;
  reg [16:0] div_ff;
  reg [4:0]  half_ff;
  reg        tb_ff;
  wire       tb_rise;
  wire       tick;

  assign tb_rise = tb_s2_ff & ~tb_d_ff;
  assign tick = master_ff ? (div_ff == MS_CYC - 1)
                          : (tb_rise && div_ff == `DTD_TB_EDGES_MS - 1);

  // ----------------------------------------------------------------
  // strap capture, master clock output and tick generation
  // ----------------------------------------------------------------
  // strapped master drives the shared time base
  assign shared_time_base_o    = tb_ff;
  assign shared_time_base_oe_o = master_ff;

  always @(posedge clk_i)
  begin
    strap_s1_ff <= oscillator_enable_i;
    strap_s2_ff <= strap_s1_ff;
    tb_s1_ff    <= shared_time_base_i;
    tb_s2_ff    <= tb_s1_ff;
    tb_d_ff     <= tb_s2_ff;
    if (!nrst_i)
    begin
      strap_done_ff <= 1'b0;
      master_ff     <= 1'b1;
      div_ff        <= 17'h0;
      half_ff       <= 5'h0;
      tb_ff         <= 1'b0;
      ms_tick_o     <= 1'b0;
    end
    else
    begin
      if (!strap_done_ff)
      begin
        strap_done_ff <= 1'b1;
        master_ff     <= strap_s2_ff;
      end
      if (half_ff == `DTD_TB_HALF_CYC - 1)
      begin
        half_ff <= 5'h0;
        tb_ff   <= ~tb_ff;
      end
      else
        half_ff <= half_ff + 5'h1;
      ms_tick_o <= tick;
      if (tick)
        div_ff <= 17'h0;
      else if (master_ff || tb_rise)
        div_ff <= div_ff + 17'h1;
    end
  end

endmodule // dtd_time_base

// ===== test/dtd_digit_out_checker.sv
// dtd_digit_out_checker: port assertions for the digit output logic
// assumes: bound to dtd_digit_out, one clock domain
`timescale 1ns/1ns
module dtd_digit_out_checker (
  input wire clk_i,
  input wire nrst_i,
  input wire output_enable_i,
  input wire valid_clear_i,
  input wire oscillator_enable_i,
  input wire shared_time_base_o,
  input wire shared_time_base_oe_o,
  input wire code_bit0_o,
  input wire code_bit1_o,
  input wire code_bit2_o,
  input wire code_bit3_o,
  input wire code_oe_o,
  input wire digit_valid_o,
  input wire early_detect_o
);
  wire [3:0] code = {code_bit3_o, code_bit2_o, code_bit1_o, code_bit0_o};
  reg  [7:0] stable_ff;
  reg  [3:0] code_ff;
  reg  [5:0] tb_cnt_ff;
  reg        tb_prev_ff;
  reg        tb_seen_ff;
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    code_ff <= code;
    tb_prev_ff <= shared_time_base_o;
    if (!nrst_i)
    begin
      stable_ff <= 8'h00;
      tb_cnt_ff <= 6'h00;
      tb_seen_ff <= 1'b0;
    end
    else
    begin
      if (code != code_ff)
        stable_ff <= 8'h00;
      else if (stable_ff != 8'hff)
        stable_ff <= stable_ff + 8'h01;
      if (shared_time_base_o != tb_prev_ff)
        tb_seen_ff <= 1'b1;
      tb_cnt_ff <= (shared_time_base_o != tb_prev_ff) ? 6'h00 : tb_cnt_ff + 6'h01;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_oe_follow: assert property (code_oe_o == $past(output_enable_i, 2))
    else $error("code enable does not follow output enable");
  chk_reset_clear: assert property ($rose(nrst_i) |-> code == 4'h0 && !digit_valid_o
    && !early_detect_o) else $error("outputs not clear after reset");
  chk_clear_drop: assert property ($rose(valid_clear_i) |-> ##[1:6] !digit_valid_o)
    else $error("valid clear did not drop valid in time");
  chk_code_steady: assert property (digit_valid_o && $past(digit_valid_o) |-> $stable(code))
    else $error("code changed while valid high");
  // 174 sampled cycles of no change means 175 clocks of setup
  chk_setup_time: assert property ($rose(digit_valid_o) |-> stable_ff >= 8'd174)
    else $error("code setup before valid too short");
  chk_valid_detect: assert property ($rose(digit_valid_o) |-> early_detect_o)
    else $error("valid rose without early detect");
  chk_tb_drive: assert property (oscillator_enable_i |-> shared_time_base_oe_o)
    else $error("master does not drive shared time base");
  chk_tb_period: assert property ((shared_time_base_o != tb_prev_ff) && tb_seen_ff
    |-> tb_cnt_ff == 6'd27) else $error("shared time base half period wrong");
endmodule // dtd_digit_out_checker

bind dtd_digit_out dtd_digit_out_checker u_chk (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .output_enable_i(output_enable_i),
  .valid_clear_i(valid_clear_i),
  .oscillator_enable_i(oscillator_enable_i),
  .shared_time_base_o(shared_time_base_o),
  .shared_time_base_oe_o(shared_time_base_oe_o),
  .code_bit0_o(code_bit0_o),
  .code_bit1_o(code_bit1_o),
  .code_bit2_o(code_bit2_o),
  .code_bit3_o(code_bit3_o),
  .code_oe_o(code_oe_o),
  .digit_valid_o(digit_valid_o),
  .early_detect_o(early_detect_o)
);

// ===== test/dtd_reader.sv
// dtd_reader: bus logic reading decoded digits
// assumes: drives on the falling edge, samples the bus on the rising edge
`timescale 1ns/1ns
module dtd_reader (
  input  wire       clk_i,
  input  wire [3:0] bus_i,
  input  wire       digit_valid_i,
  input  wire       clear_req_i,
  output wire       valid_clear_o,
  output wire [3:0] code_o
);
  reg [2:0] width_ff = 3'h0;
  reg [3:0] code_ff  = 4'h0;
  always @(negedge clk_i)
  begin
    if (clear_req_i && width_ff == 3'h0)
      width_ff <= 3'h5;
    else if (width_ff != 3'h0)
      width_ff <= width_ff - 3'h1;
  end
  assign valid_clear_o = (width_ff != 3'h0);
  // code taken only while valid high
  always @(posedge clk_i)
  begin
    if (digit_valid_i)
      code_ff <= bus_i;
  end
  assign code_o = code_ff;
endmodule // dtd_reader

// ===== test/dtd_digit_out_bench.sv
// dtd_digit_out_bench: self-checking bench for the digit output logic
// assumes: 25 mhz clock, one millisecond shortened to MS clocks
`timescale 1ns/1ns
module dtd_digit_out_bench;
  localparam MS   = 20;
  localparam HOLD = 92;
  localparam [63:0] HEX_TAB = 64'h0cabf987e654d321;
  reg        clk     = 1'b0;
  reg        nrst    = 1'b0;
  reg        tone    = 1'b0;
  reg  [1:0] row     = 2'h0;
  reg  [1:0] col     = 2'h0;
  reg        hex     = 1'b1;
  reg        inh     = 1'b0;
  reg        oen     = 1'b1;
  reg        clr_req = 1'b0;
  reg        osc     = 1'b1;
  wire       tb_o, tb_oe, b0, b1, b2, b3, c_oe, dv, ed, vclr;
  wire [3:0] code    = {b3, b2, b1, b0};
  wire [3:0] bus     = c_oe ? code : 4'bzzzz;
  wire [3:0] rd_code;
  wire       tb_pin  = tb_oe ? tb_o : 1'b0;
  integer    errors  = 0;
  integer    compares = 0;
  integer    n;
  dtd_digit_out #(.MS_CYC(MS), .HOLD_CYC(HOLD), .REDUCED(0)) DUT (
    .clk_i(clk), .nrst_i(nrst), .tone_present_i(tone), .tone_row_i(row),
    .tone_col_i(col), .output_format_select_i(hex), .fourth_column_inhibit_i(inh),
    .output_enable_i(oen), .valid_clear_i(vclr), .oscillator_enable_i(osc),
    .shared_time_base_i(tb_pin), .shared_time_base_o(tb_o),
    .shared_time_base_oe_o(tb_oe), .code_bit0_o(b0), .code_bit1_o(b1),
    .code_bit2_o(b2), .code_bit3_o(b3), .code_oe_o(c_oe), .digit_valid_o(dv),
    .early_detect_o(ed));
  dtd_reader u_rd (.clk_i(clk), .bus_i(bus), .digit_valid_i(dv),
    .clear_req_i(clr_req), .valid_clear_o(vclr), .code_o(rd_code));
  initial
  begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check(input [15:0] seen, input [15:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  function [15:0] in_rng(input integer v, input integer lo, input integer hi);
    in_rng = (v >= lo && v <= hi);
  endfunction
  function sig(input [1:0] s);
    sig = (s == 2'd0) ? dv : (s == 2'd1) ? ed : (code == 4'h0);
  endfunction
  task wait_for(input [1:0] s, input v, input integer lim);
  begin
    while (sig(s) !== v && n < lim)
    begin
      @(negedge clk);
      n = n + 1;
    end
  end
  endtask
  task put(input t, input [1:0] r, input [1:0] c);
  begin
    @(negedge clk);
    tone = t;
    row = r;
    col = c;
  end
  endtask
  task idle(input integer ms);
  begin
    repeat (ms * MS) @(negedge clk);
  end
  endtask
  task do_digit(input [1:0] r, input [1:0] c);
    reg [3:0] exp;
  begin
    exp = hex ? HEX_TAB[{r, c} * 4 +: 4] : {r, c};
    put(1'b1, r, c);
    n = 0;
    wait_for(2'd1, 1'b1, 22 * MS);
    check(in_rng(n, 7 * MS, 22 * MS), 16'h1);
    wait_for(2'd0, 1'b1, 46 * MS);
    check(in_rng(n, 25 * MS, 46 * MS), 16'h1);
    check(bus, exp);
    repeat (40 * MS - n) @(negedge clk);
    check(rd_code, exp);
    put(1'b0, r, c);
    n = 0;
    wait_for(2'd1, 1'b0, 18 * MS);
    check(in_rng(n, 2 * MS, 18 * MS), 16'h1);
    wait_for(2'd0, 1'b0, 50 * MS);
    check(in_rng(n, 35 * MS, 50 * MS), 16'h1);
    n = 0;
    wait_for(2'd2, 1'b1, 110);
    if (exp != 4'h0)
      check(in_rng(n, 84, 100), 16'h1);
    repeat (110 - n) @(negedge clk);
  end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_codes;
    integer i;
  begin
    for (i = 0; i < 32; i = i + 1)
    begin
      hex = (i < 16);
      do_digit(i[3:2], i[1:0]);
    end
    hex = 1'b1;
    $display("test codes done");
  end
  endtask
  task t_short;
  begin
    put(1'b1, 2'h1, 2'h1);
    idle(20);
    put(1'b0, 2'h1, 2'h1);
    n = 0;
    wait_for(2'd0, 1'b1, 40 * MS);
    check({dv, code}, 16'h0);
    put(1'b1, 2'h2, 2'h0);
    n = 0;
    wait_for(2'd0, 1'b1, 46 * MS);
    put(1'b0, 2'h2, 2'h0);
    n = 0;
    wait_for(2'd0, 1'b0, 20 * MS);
    put(1'b1, 2'h2, 2'h0);
    check(dv, 16'h1);
    idle(10);
    put(1'b0, 2'h2, 2'h0);
    idle(60);
    $display("test short done");
  end
  endtask
  task t_inhibit;
  begin
    inh = 1'b1;
    put(1'b1, 2'h0, 2'h3);
    n = 0;
    wait_for(2'd0, 1'b1, 46 * MS);
    check(dv, 16'h0);
    put(1'b0, 2'h0, 2'h3);
    idle(5);
    put(1'b1, 2'h0, 2'h0);
    n = 0;
    wait_for(2'd0, 1'b1, 46 * MS);
    check({dv, code}, 16'h11);
    put(1'b0, 2'h0, 2'h0);
    idle(45);
    inh = 1'b0;
    $display("test inhibit done");
  end
  endtask
  task t_clear;
  begin
    put(1'b1, 2'h1, 2'h2);
    n = 0;
    wait_for(2'd0, 1'b1, 46 * MS);
    clr_req <= 1'b1;
    @(negedge clk);
    clr_req <= 1'b0;
    n = 0;
    wait_for(2'd0, 1'b0, 8);
    check(in_rng(n, 1, 6), 16'h1);
    oen = 1'b0;
    repeat (6) @(negedge clk);
    check({dv, bus}, {12'h0, 4'bzzzz});
    oen = 1'b1;
    repeat (3) @(negedge clk);
    check(bus, 16'h6);
    put(1'b0, 2'h1, 2'h2);
    idle(45);
    check(code, 16'h0);
    $display("test clear done");
  end
  endtask
  task t_restart;
  begin
    nrst = 1'b0;
    osc = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    check({dv, ed, code}, 16'h0);
    repeat (3) @(negedge clk);
    check(tb_oe, 16'h0);
    put(1'b1, 2'h0, 2'h0);
    idle(30);
    check({ed, dv}, 16'h0);
    put(1'b0, 2'h0, 2'h0);
    nrst = 1'b0;
    osc = 1'b1;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check(tb_oe, 16'h1);
    $display("test restart done");
  end
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task conclude;
  begin
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    check({dv, ed, code}, 16'h0);
    t_codes;
    t_short;
    t_inhibit;
    t_clear;
    t_restart;
    conclude;
  end
  initial
  begin
    #(90000 * 40);
    errors = errors + 1;
    conclude;
  end
endmodule // dtd_digit_out_bench
